// *** hw/graphics_ram_pkg.sv ***
// constants, encodings and state type for the graphics RAM write path
package graphics_ram_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0]  OFS_ENTRY    = 8'h00;
  localparam logic [7:0]  OFS_COMPARE  = 8'h04;
  localparam logic [7:0]  OFS_MASK     = 8'h08;
  localparam logic [7:0]  OFS_ADDR     = 8'h0c;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  // entry mode field positions
  localparam int          ENTRY_SWP    = 8;
  localparam int          ENTRY_DIR    = 4;
  localparam int          ENTRY_AM     = 3;
  localparam int          ENTRY_OP_HI  = 2;
  // status field positions
  localparam int          STAT_PHASE   = 8;
  localparam int          STAT_BUSY    = 9;
  // reset values
  localparam logic [15:0] ENTRY_RST    = 16'h0000;
  localparam logic [7:0]  COMPARE_RST  = 8'h00;
  localparam logic [15:0] MASK_RST     = 16'h0000;
  localparam logic [14:0] ADDR_RST     = 15'h0000;
  localparam logic [7:0]  INDEX_RST    = 8'h00;
  // host pin interface
  localparam logic [1:0]  IFSEL_68_8   = 2'b01;
  localparam logic [1:0]  IFSEL_80_8   = 2'b11;
  localparam logic [7:0]  IDX_RAM_DATA = 8'h22;
  localparam logic [7:0]  SYNC_BYTE    = 8'h00;
  localparam logic [2:0]  SYNC_COUNT   = 3'h4;
  // address counter geometry: column in bits 7:0, raster row in 14:8
  localparam logic [7:0]  COL_FIRST    = 8'h00;
  localparam logic [7:0]  COL_LAST     = 8'h3f;
  localparam logic [6:0]  ROW_FIRST    = 7'h00;
  localparam logic [6:0]  ROW_LAST     = 7'h4f;
  localparam logic [14:0] AC_VSTEP     = 15'h0100;
  // logical and compare operations
  typedef enum logic [2:0] {
    OP_REPLACE  = 3'h0,
    OP_OR       = 3'h1,
    OP_AND      = 3'h2,
    OP_XOR      = 3'h3,
    OP_EQ_LATCH = 3'h4,
    OP_NE_LATCH = 3'h5,
    OP_EQ_HOST  = 3'h6,
    OP_NE_HOST  = 3'h7
  } op_t;
  // write sequencer states, gray along idle-read-latch-write
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_LATCH = 2'b11,
    ST_WRITE = 2'b10
  } wr_state_t;
endpackage : graphics_ram_pkg

// *** hw/pixel_op_unit.sv ***
// per-byte logical and compare operation between host word, read latch and compare value
`timescale 1ns/1ns
module pixel_op_unit
  import graphics_ram_pkg::*;
(
  // clock for checks only
  input  wire logic        clk,
  input  wire logic        rst,
  // operands
  input  wire op_t         op,
  input  wire logic [15:0] host_word,
  input  wire logic [15:0] latch_word,
  input  wire logic [7:0]  compare_value,
  // results
  output logic [15:0]      result,
  output logic [1:0]       byte_ok,
  output logic             need_read
);
  assign result    = (op == OP_OR)  ? (latch_word | host_word) :
                     (op == OP_AND) ? (latch_word & host_word) :
                     (op == OP_XOR) ? (latch_word ^ host_word) : host_word;
  // read only where latch is used
  assign need_read = (op != OP_REPLACE) && (op != OP_EQ_HOST) && (op != OP_NE_HOST);

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      wire logic lat_eq = (latch_word[8*b +: 8] == compare_value);
      wire logic hst_eq = (host_word[8*b +: 8] == compare_value);
      assign byte_ok[b] = (op == OP_EQ_LATCH) ? lat_eq :
                          (op == OP_NE_LATCH) ? !lat_eq :
                          (op == OP_EQ_HOST)  ? hst_eq :
                          (op == OP_NE_HOST)  ? !hst_eq : 1'b1;
    end
  endgenerate

  latch_eq_a: assert property (@(posedge clk) disable iff (rst)
    (op == OP_EQ_LATCH) |-> (byte_ok[1] == (latch_word[15:8] == compare_value)))
    else $error("equal-latch condition wrong on upper byte");
  host_ne_a: assert property (@(posedge clk) disable iff (rst)
    (op == OP_NE_HOST) |-> (byte_ok[0] == (host_word[7:0] != compare_value)) && !need_read)
    else $error("differ-host condition wrong on lower byte");
endmodule : pixel_op_unit

// *** hw/graphics_ram_write_path.sv ***
// host write path into graphics RAM: byte pairing, swap, operations, mask, address counter
`timescale 1ns/1ns
module graphics_ram_write_path
  import graphics_ram_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // host parallel pins
  input  wire logic [1:0]  interface_select_pins,
  input  wire logic [7:0]  db_upper,
  input  wire logic        reg_select,
  input  wire logic        e_strobe,
  input  wire logic        rw_sel,
  input  wire logic        wr_n,
  // graphics RAM port
  output logic [14:0]      ram_addr,
  output logic             ram_re,
  input  wire logic [15:0] ram_rdata,
  output logic             ram_we,
  output logic [15:0]      ram_wdata,
  output logic [15:0]      ram_bwe
);
  // registers
  logic [15:0] entry_r;
  logic [7:0]  compare_r;
  logic [15:0] mask_r;
  logic [14:0] ac_r;
  logic [7:0]  index_r;
  logic [7:0]  hi_byte_r;
  logic        phase_r;
  logic [2:0]  zero_cnt_r;
  logic        e_q_r;
  logic        wr_n_q_r;
  logic [15:0] word_r;
  logic [15:0] latch_r;
  logic [15:0] wdata_r;
  logic [15:0] bwe_r;
  logic [31:0] rdata_r;
  logic        dp_write_r;
  logic [7:0]  dp_addr_r;
  wr_state_t   state_r;
  wr_state_t   state_nxt;

  // AHB-Lite address phase decode
  wire logic        ahb_take  = hsel && htrans[1] && hready;
  wire logic        ahb_wr    = dp_write_r;
  wire logic        sel_entry = (dp_addr_r == OFS_ENTRY);
  wire logic        sel_cmp   = (dp_addr_r == OFS_COMPARE);
  wire logic        sel_mask  = (dp_addr_r == OFS_MASK);
  wire logic        sel_addr  = (dp_addr_r == OFS_ADDR);
  wire logic [7:0]  rd_ofs    = haddr[7:0];
  wire logic [31:0] status_w  = {22'h000000, state_r != ST_IDLE, phase_r, index_r};
  wire logic [31:0] rd_mux    = (rd_ofs == OFS_ENTRY)   ? {16'h0000, entry_r} :
                                (rd_ofs == OFS_COMPARE) ? {24'h000000, compare_r} :
                                (rd_ofs == OFS_MASK)    ? {16'h0000, mask_r} :
                                (rd_ofs == OFS_ADDR)    ? {17'h00000, ac_r} :
                                (rd_ofs == OFS_STATUS)  ? status_w : 32'h00000000;
  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // AHB-Lite phase registers and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_write_r <= 1'b0;
      dp_addr_r  <= OFS_ENTRY;
      rdata_r    <= 32'h00000000;
    end else begin
      dp_write_r <= ahb_take && hwrite;
      dp_addr_r  <= haddr[7:0];
      if (ahb_take && !hwrite) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      entry_r   <= ENTRY_RST;
      compare_r <= COMPARE_RST;
      mask_r    <= MASK_RST;
    end else if (ahb_wr) begin
      if (sel_entry) entry_r <= hwdata[15:0] & 16'h011f;
      if (sel_cmp)   compare_r <= hwdata[7:0];
      if (sel_mask)  mask_r <= hwdata[15:0];
    end
  end

  // entry mode fields
  wire logic swap_en  = entry_r[ENTRY_SWP];
  wire logic step_up  = entry_r[ENTRY_DIR];
  wire logic vertical = entry_r[ENTRY_AM];
  wire op_t  op_sel   = op_t'(entry_r[ENTRY_OP_HI:0]);

  wire logic strobe_68 = (interface_select_pins == IFSEL_68_8) && e_q_r && !e_strobe && !rw_sel;
  wire logic strobe_80 = (interface_select_pins == IFSEL_80_8) && !wr_n_q_r && wr_n;
  wire logic byte_in   = strobe_68 || strobe_80;
  wire logic zero_byte = byte_in && !reg_select && (db_upper == SYNC_BYTE);
  wire logic sync_hit  = zero_byte && (zero_cnt_r == SYNC_COUNT - 3'h1);
  // word completes on the lower byte
  wire logic word_done = byte_in && phase_r && !sync_hit;
  wire logic [15:0] word_in  = {hi_byte_r, db_upper};
  wire logic [15:0] word_swp = swap_en ? {word_in[7:0], word_in[15:8]} : word_in;
  wire logic data_go  = word_done && reg_select && (index_r == IDX_RAM_DATA) && (state_r == ST_IDLE);

  // strobe edges, byte pairing and resync
  always_ff @(posedge clk) begin
    if (rst) begin
      e_q_r      <= 1'b0;
      wr_n_q_r   <= 1'b1;
      phase_r    <= 1'b0;
      hi_byte_r  <= 8'h00;
      zero_cnt_r <= 3'h0;
      index_r    <= INDEX_RST;
    end else begin
      e_q_r    <= e_strobe;
      wr_n_q_r <= wr_n;
      if (byte_in) begin
        zero_cnt_r <= (zero_byte && !sync_hit) ? zero_cnt_r + 3'h1 : 3'h0;
        if (sync_hit) begin
          phase_r <= 1'b0;
        end else begin
          phase_r <= !phase_r;
        end
        if (!phase_r) hi_byte_r <= db_upper;
        // index taken from the lower byte of a pair
        if (word_done && !reg_select) index_r <= db_upper;
      end
    end
  end

  // operation unit
  wire logic [15:0] op_latch = (state_r == ST_LATCH) ? ram_rdata : latch_r;
  wire logic [15:0] op_host  = (state_r == ST_IDLE) ? word_swp : word_r;
  logic [15:0] op_result;
  logic [1:0]  op_ok;
  logic        op_need_read;
  pixel_op_unit u_op (
    .clk           (clk),
    .rst           (rst),
    .op            (op_sel),
    .host_word     (op_host),
    .latch_word    (op_latch),
    .compare_value (compare_r),
    .result        (op_result),
    .byte_ok       (op_ok),
    .need_read     (op_need_read)
  );
  // mask gates per-bit enables after swap and operation
  wire logic [15:0] bwe_calc = ~mask_r & {{8{op_ok[1]}}, {8{op_ok[0]}}};

  // write sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (data_go) state_nxt = op_need_read ? ST_READ : ST_WRITE;
      ST_READ:  state_nxt = ST_LATCH;
      ST_LATCH: state_nxt = ST_WRITE;
      ST_WRITE: state_nxt = ST_IDLE;
    endcase
  end
  assign ram_re    = (state_r == ST_READ);
  assign ram_we    = (state_r == ST_WRITE);
  assign ram_addr  = ac_r;
  assign ram_wdata = wdata_r;
  assign ram_bwe   = bwe_r;

  // sequencer, latch and write data
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      word_r  <= 16'h0000;
      latch_r <= 16'h0000;
      wdata_r <= 16'h0000;
      bwe_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (data_go) word_r <= word_swp;
      // original word held in read latch
      if (state_r == ST_LATCH) latch_r <= ram_rdata;
      if (state_nxt == ST_WRITE) begin
        wdata_r <= op_result;
        bwe_r   <= bwe_calc;
      end
    end
  end

  // address counter step terms
  wire logic [7:0]  col     = ac_r[7:0];
  wire logic [6:0]  row     = ac_r[14:8];
  wire logic [6:0]  row_inc = (row == ROW_LAST) ? ROW_FIRST : row + 7'h01;
  wire logic        h_wrap  = step_up ? (col == COL_LAST) : (col == COL_FIRST);
  wire logic [7:0]  h_col   = step_up ? ((col == COL_LAST) ? COL_FIRST : col + 8'h01) :
                                        ((col == COL_FIRST) ? COL_LAST : col - 8'h01);
  wire logic [14:0] ac_h    = {h_wrap ? row_inc : row, h_col};
  // vertical step, wrap to top edge
  wire logic [14:0] ac_v    = (row == ROW_LAST) ? {ROW_FIRST, step_up ? COL_LAST : COL_FIRST} : ac_r + AC_VSTEP;
  wire logic [14:0] ac_step = vertical ? ac_v : ac_h;

  // address counter: software load, else step after each RAM write
  always_ff @(posedge clk) begin
    if (rst) begin
      ac_r <= ADDR_RST;
    end else if (ahb_wr && sel_addr) begin
      ac_r <= hwdata[14:0];
    end else if (state_r == ST_WRITE) begin
      ac_r <= ac_step;
    end
  end

  // checks
  sequence s_read_cycle;
    (state_r == ST_READ) ##1 (state_r == ST_LATCH) ##1 (state_r == ST_WRITE);
  endsequence
  sequence s_write_now;
    ##[1:1] ram_we;
  endsequence

  sync_clear_a: assert property (@(posedge clk) disable iff (rst)
    sync_hit |=> !phase_r && (zero_cnt_r == 3'h0))
    else $error("resync did not clear byte phase");
  swap_word_a: assert property (@(posedge clk) disable iff (rst)
    data_go |=> (word_r == (swap_en ? {$past(word_in[7:0]), $past(word_in[15:8])} : $past(word_in))))
    else $error("host word not exchanged as flag says");
  direct_write_a: assert property (@(posedge clk) disable iff (rst)
    (data_go && op_sel == OP_REPLACE) |-> !ram_re ##1 (ram_we && wdata_r == word_r))
    else $error("replace mode did not write host word directly");
  read_modify_a: assert property (@(posedge clk) disable iff (rst)
    (data_go && (op_sel == OP_XOR)) |=> s_read_cycle ##0 (wdata_r == (latch_r ^ word_r)))
    else $error("exclusive-or read-modify-write wrong");
  mask_gate_a: assert property (@(posedge clk) disable iff (rst)
    ram_we |-> ((ram_bwe & $past(mask_r)) == 16'h0000))
    else $error("masked bit enabled for write");
  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_LATCH) |-> s_write_now ##0 (latch_r == $past(ram_rdata)))
    else $error("read latch not captured before write");
  horiz_step_a: assert property (@(posedge clk) disable iff (rst)
    (ram_we && !vertical && step_up && col != COL_LAST && !(ahb_wr && sel_addr))
      |=> (ac_r == $past(ac_r) + 15'h0001))
    else $error("horizontal increment wrong");
  vert_step_a: assert property (@(posedge clk) disable iff (rst)
    (ram_we && vertical && row == ROW_LAST && !(ahb_wr && sel_addr))
      |=> (ac_r[14:8] == ROW_FIRST) && (ac_r[7:0] == ($past(step_up) ? COL_LAST : COL_FIRST)))
    else $error("vertical wrap to top edge wrong");
  vert_add_a: assert property (@(posedge clk) disable iff (rst)
    (ram_we && vertical && row != ROW_LAST && !(ahb_wr && sel_addr))
      |=> (ac_r == $past(ac_r) + AC_VSTEP))
    else $error("vertical step of one row wrong");
  config_reset_a: assert property (@(posedge clk)
    $past(rst) |-> (entry_r == ENTRY_RST) && (compare_r == COMPARE_RST) && (mask_r == MASK_RST))
    else $error("configuration not zero after reset");
endmodule : graphics_ram_write_path

// *** tb/host_bus_model.sv ***
// host microcomputer model driving the byte-wide parallel pins
`timescale 1ns/1ns
module host_bus_model
  import graphics_ram_pkg::*;
(
  // clock
  input  wire logic       clk,
  // strap selecting the bus style
  input  wire logic [1:0] interface_select_pins,
  // parallel pins
  output logic [7:0]      db_upper,
  output logic            reg_select,
  output logic            e_strobe,
  output logic            rw_sel,
  output logic            wr_n
);
  // extra cycles the strobe is held, for slow hosts
  int unsigned hold;
  // idle pins: strobes off, write direction
  initial begin
    hold       = 0;
    db_upper   = 8'h00;
    reg_select = 1'b0;
    e_strobe   = 1'b0;
    rw_sel     = 1'b0;
    wr_n       = 1'b1;
  end
  task automatic send_byte(input logic rs, input logic [7:0] b);
    @(posedge clk);
    db_upper   <= b;
    reg_select <= rs;
    e_strobe   <= (interface_select_pins == IFSEL_68_8);
    wr_n       <= (interface_select_pins != IFSEL_80_8);
    repeat (hold + 1) @(posedge clk);
    e_strobe <= 1'b0;
    wr_n     <= 1'b1;
    @(posedge clk);
    // released lines show the inverse of the last byte
    db_upper <= ~b;
  endtask : send_byte
  // upper byte first, index as a full pair
  task automatic send_word(input logic rs, input logic [15:0] w);
    send_byte(rs, w[15:8]);
    send_byte(rs, w[7:0]);
  endtask : send_word
  task automatic resync();
    repeat (4) send_byte(1'b0, SYNC_BYTE);
  endtask : resync
endmodule : host_bus_model

// *** tb/tb_top.sv ***
// self-checking bench for the graphics RAM write path
`timescale 1ns/1ns
module tb_top;
  import graphics_ram_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, e;
  logic [1:0]  htrans, ifsel;
  logic [2:0]  hsize, o;
  logic [7:0]  db;
  logic        rs, es, rw, wrn, ram_re, ram_we;
  logic [14:0] ram_addr, cap_addr;
  logic [15:0] ram_rdata, ram_wdata, ram_bwe, ram_val, cap_data, cap_bwe, h, msk, eb;
  int          n_fail, comparisons, n_wr, n_rd, n0, r0;
  logic [15:0] ent [7] = '{16'h10, 16'h00, 16'h10, 16'h18, 16'h18, 16'h08, 16'h10};
  logic [14:0] st [7] = '{15'h3f, 15'h100, 15'h205, 15'h305, 15'h4f10, 15'h4f10, 15'h4f3f};
  logic [14:0] nx [7] = '{15'h100, 15'h23f, 15'h206, 15'h405, 15'h3f, 15'h0, 15'h0};

  graphics_ram_write_path i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .interface_select_pins(ifsel), .db_upper(db),
    .reg_select(rs), .e_strobe(es), .rw_sel(rw), .wr_n(wrn), .ram_addr(ram_addr), .ram_re(ram_re),
    .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_bwe(ram_bwe));
  host_bus_model i_host (.clk(clk), .interface_select_pins(ifsel), .db_upper(db),
    .reg_select(rs), .e_strobe(es), .rw_sel(rw), .wr_n(wrn));

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ram model: one cycle read latency, noise when not read
  always @(posedge clk) begin
    ram_rdata <= (ram_re === 1'b1) ? ram_val : ~ram_rdata;
    if (ram_re === 1'b1) n_rd <= n_rd + 1;
    if (ram_we === 1'b1) begin
      n_wr     <= n_wr + 1;
      cap_addr <= ram_addr;
      cap_data <= ram_wdata;
      cap_bwe  <= ram_bwe;
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_ready
  // one single word transfer: address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, ex, x);
    chk("response", 32'h0, {31'h0, hresp});
  endtask : rdc
  // send a data word and wait for its ram write
  task automatic put(input logic [15:0] w);
    int n;
    n0 = n_wr;
    r0 = n_rd;
    i_host.send_word(1'b1, w);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n_wr == n0 && n < 40);
    if (n_wr == n0) begin
      n_fail++;
      report_and_stop();
    end
  endtask : put
  // expected enables and data of one word, before the mask
  function automatic logic [31:0] exp_of(input logic [2:0] op, input logic [15:0] hw, lw, input logic [7:0] c);
    logic [1:0]  ok;
    logic [15:0] d;
    d  = hw;
    ok = 2'b11;
    case (op)
      3'h1: d = lw | hw;
      3'h2: d = lw & hw;
      3'h3: d = lw ^ hw;
      3'h4: ok = {lw[15:8] == c, lw[7:0] == c};
      3'h5: ok = {lw[15:8] != c, lw[7:0] != c};
      3'h6: ok = {hw[15:8] == c, hw[7:0] == c};
      3'h7: ok = {hw[15:8] != c, hw[7:0] != c};
      default: ;
    endcase
    return {{8{ok[1]}}, {8{ok[0]}}, d};
  endfunction : exp_of
  // main sequence
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    {hsize, ifsel, ram_val, ram_rdata} = {3'b010, IFSEL_68_8, 32'h0};
    {n_fail, comparisons, n_wr, n_rd} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("entry", OFS_ENTRY, 32'h0);
    rdc("compare", OFS_COMPARE, 32'h0);
    rdc("mask", OFS_MASK, 32'h0);
    rdc("counter", OFS_ADDR, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    i_host.send_word(1'b0, {8'h00, IDX_RAM_DATA});
    ram_val = 16'h3c5a;
    for (int i = 0; i < 8; i++) begin
      o = i[2:0];
      @(posedge clk);
      ifsel <= o[1] ? IFSEL_80_8 : IFSEL_68_8;
      i_host.hold = i % 3;
      msk = o[1] ? 16'h0f00 : 16'h0000;
      h = o[0] ? 16'h965a : 16'h5a96;
      wr(OFS_ENTRY, {23'h0, o[0], 3'b000, 1'b1, 1'b0, o});
      wr(OFS_COMPARE, 32'h5a);
      wr(OFS_MASK, {16'h0, msk});
      wr(OFS_ADDR, 32'h10 + i);
      put(16'h5a96);
      e = exp_of(o, h, ram_val, 8'h5a);
      eb = e[31:16] & ~msk;
      chk("ram data", {16'h0, e[15:0] & eb}, {16'h0, cap_data & cap_bwe});
      chk("bit enables", {16'h0, eb}, {16'h0, cap_bwe});
      chk("ram reads", (i >= 1 && i <= 5) ? 32'h1 : 32'h0, n_rd - r0);
      chk("ram address", 32'h10 + i, {17'h0, cap_addr});
    end
    for (int i = 0; i < 7; i++) begin
      wr(OFS_ENTRY, {16'h0, ent[i]});
      wr(OFS_ADDR, {17'h0, st[i]});
      put(16'h1111);
      rdc("counter", OFS_ADDR, {17'h0, nx[i]});
    end
    i_host.send_byte(1'b0, 8'h11);
    rdc("status", OFS_STATUS, 32'h122);
    i_host.resync();
    i_host.send_word(1'b0, {8'h00, IDX_RAM_DATA});
    wr(OFS_ENTRY, 32'h10);
    wr(OFS_MASK, 32'h0);
    put(16'h1234);
    chk("ram data", 32'h1234, {16'h0, cap_data});
    chk("bit enables", 32'hffff, {16'h0, cap_bwe});
    report_and_stop();
  end
endmodule : tb_top
